// ===== rtl/ids_pkg.sv
// Package with constants and types for the input debounce scanner
package ids_pkg;
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned NUM_IN       = 12;
	// Times in microseconds as printed, except DLY_25_NS in nanoseconds
	localparam int unsigned DEB_DC_US    = 20_000;
	localparam int unsigned DLY_25_NS    = 25_000;
	localparam int unsigned DLY_250_US   = 250;
	localparam int unsigned DLY_400_US   = 400;
	localparam int unsigned DLY_200_US   = 200;
	localparam int unsigned LONG50_US    = 40_000;
	localparam int unsigned LONG60_US    = 33_300;
	localparam int unsigned SHORT50_US   = 20_000;
	localparam int unsigned SHORT60_US   = 16_700;
	localparam int unsigned SCREEN_B_US  = 80;
	// Cycle counts (1 us = 50 cycles)
	localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
	localparam int unsigned DEB_DC_CYC   = DEB_DC_US * CYC_PER_US;
	localparam int unsigned DLY_25_CYC   = (DLY_25_NS * CYC_PER_US + 999) / 1000;
	localparam int unsigned DLY_250_CYC  = DLY_250_US * CYC_PER_US;
	localparam int unsigned DLY_400_CYC  = DLY_400_US * CYC_PER_US;
	localparam int unsigned DLY_200_CYC  = DLY_200_US * CYC_PER_US;
	localparam int unsigned LONG50_CYC   = LONG50_US * CYC_PER_US;
	localparam int unsigned LONG60_CYC   = LONG60_US * CYC_PER_US;
	localparam int unsigned SHORT50_CYC  = SHORT50_US * CYC_PER_US;
	localparam int unsigned SHORT60_CYC  = SHORT60_US * CYC_PER_US;
	localparam int unsigned SCREEN_B_CYC = SCREEN_B_US * CYC_PER_US;
	localparam int unsigned CNT_W        = 24;
	localparam int unsigned FC_W         = 16;
	// Configuration carried as one struct
	typedef struct packed {
		logic debounce_en;  // Debounce on
		logic ac_mode;      // Inputs are AC half-wave
		logic mains_60hz;   // 60 Hz mains
	} ids_cfg_t;
	typedef enum logic [1:0] {IDS_IDLE, IDS_LOAD, IDS_WAIT} ids_scr_t;
endpackage

// ===== rtl/ids_scanner.sv
// Input debounce scanner: DC/AC filtering, frozen image, fast counters
module ids_scanner import ids_pkg::*; #(
	parameter int unsigned DEB_CYC   = DEB_DC_CYC,
	parameter int unsigned L50_CYC   = LONG50_CYC,
	parameter int unsigned L60_CYC   = LONG60_CYC,
	parameter int unsigned S50_CYC   = SHORT50_CYC,
	parameter int unsigned S60_CYC   = SHORT60_CYC,
	parameter int unsigned D250_CYC  = DLY_250_CYC,
	parameter int unsigned D400_CYC  = DLY_400_CYC,
	parameter int unsigned D200_CYC  = DLY_200_CYC
) (
	input  wire logic              clk_sys,         // 50 MHz clock
	input  wire logic              rst,             // Async reset, high
	input  wire logic [NUM_IN-1:0] input_terminals, // Raw terminal levels
	input  wire ids_cfg_t          cfg,             // Debounce/AC/mains setting
	input  wire logic              cycle_start,     // Program cycle start pulse
	input  wire logic [15:0]       screen_bytes,    // Screen size for load
	input  wire logic              screen_load,     // Mask change pulse
	output logic [NUM_IN-1:0]      image_r,         // Frozen input image
	output logic [FC_W-1:0]        fast_counter_a,  // Counts on input 1
	output logic [FC_W-1:0]        fast_counter_b,  // Counts on input 2
	output logic [FC_W-1:0]        fast_counter_c,  // Counts on input 3
	output logic                   screen_busy_r    // Screen load active
);
	logic [NUM_IN-1:0] sync1_r, sync2_r, filt_r, prev_r;
	logic [CNT_W-1:0]  scan_cnt_r;
	logic              scan_tick;
	logic [CNT_W-1:0]  scan_len;

	// Two-flop synchroniser for terminals
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= input_terminals;
			sync2_r <= sync1_r;
		end
	end

	// AC scan period: long with debounce, short without, by mains
	always_comb begin
		if (cfg.debounce_en)
			scan_len = cfg.mains_60hz ? CNT_W'(L60_CYC) : CNT_W'(L50_CYC);
		else
			scan_len = cfg.mains_60hz ? CNT_W'(S60_CYC) : CNT_W'(S50_CYC);
	end
	assign scan_tick = (scan_cnt_r >= scan_len - CNT_W'(1));

	// Shared scan period divider
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			scan_cnt_r <= '0;
		else if (scan_tick)
			scan_cnt_r <= '0;
		else
			scan_cnt_r <= scan_cnt_r + CNT_W'(1);
	end

	// Per-input filter, one slice per terminal
	// DC slices count persistence of a pending edge; AC slices latch half-waves
	// Mode changes clear the other mode's state, so no stale count survives
	// A setting change mid-period only shortens or stretches that one period
	genvar g;
	generate
		for (g = 0; g < NUM_IN; g++) begin : g_in
			logic [CNT_W-1:0] cnt_r;      // DC persistence counter
			logic             seen_r;     // Half-wave seen this period
			logic [1:0]       hist_r;     // Last two period results
			logic [CNT_W-1:0] on_len;     // Cycles a rise must persist
			logic [CNT_W-1:0] off_len;    // Cycles a fall must persist
			logic [CNT_W-1:0] dc_len;     // Persistence for the pending edge
			logic             period_hit; // Half-wave in the closing period
			logic             dc_done;    // DC level persisted long enough
			logic             dc_flt_nxt; // DC filter next value
			logic             ac_flt_nxt; // AC filter next value

			// Rise delay: fast group or slow group, or debounce time
			always_comb begin
				if (cfg.debounce_en)
					on_len = CNT_W'(DEB_CYC);
				else if (g < 4)
					on_len = CNT_W'(DLY_25_CYC);
				else
					on_len = CNT_W'(D250_CYC);
			end

			// Fall delay: three hardware groups, or debounce time
			always_comb begin
				if (cfg.debounce_en)
					off_len = CNT_W'(DEB_CYC);
				else if (g < 4)
					off_len = CNT_W'(DLY_25_CYC);
				else if (g == 6 || g == 7 || g == 10 || g == 11)
					off_len = CNT_W'(D200_CYC);
				else
					off_len = CNT_W'(D400_CYC);
			end

			// Pending edge picks its own persistence time
			assign dc_len     = sync2_r[g] ? on_len : off_len;
			assign dc_done    = (sync2_r[g] != filt_r[g]) && (cnt_r >= dc_len - CNT_W'(1));
			assign period_hit = seen_r | sync2_r[g];

			// DC persistence counter, any reversal restarts it
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst)
					cnt_r <= '0;
				else if (cfg.ac_mode || sync2_r[g] == filt_r[g] || dc_done)
					cnt_r <= '0;
				else
					cnt_r <= cnt_r + CNT_W'(1);
			end

			// Half-wave latch, cleared at each period end
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst)
					seen_r <= 1'b0;
				else if (!cfg.ac_mode || scan_tick)
					seen_r <= 1'b0;
				else if (sync2_r[g])
					seen_r <= 1'b1;
			end

			// Period history for the two-period AC decision
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst)
					hist_r <= 2'h0;
				else if (!cfg.ac_mode)
					hist_r <= 2'h0;
				else if (scan_tick)
					hist_r <= {hist_r[0], period_hit};
			end

			// DC next value: take the level once it persisted
			always_comb begin
				dc_flt_nxt = filt_r[g];
				if (dc_done)
					dc_flt_nxt = sync2_r[g];
			end

			// AC next value at period end; bounce may miss one period
			always_comb begin
				ac_flt_nxt = filt_r[g];
				if (scan_tick) begin
					if (!cfg.debounce_en)
						ac_flt_nxt = period_hit;
					else if (hist_r[0] && period_hit)
						ac_flt_nxt = 1'b1;
					else if (!hist_r[0] && !period_hit)
						ac_flt_nxt = 1'b0;
				end
			end

			// Filtered contact state
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst)
					filt_r[g] <= 1'b0;
				else
					filt_r[g] <= cfg.ac_mode ? ac_flt_nxt : dc_flt_nxt;
			end
		end
	endgenerate

	// Image updates only at cycle start, frozen otherwise
	// Link traffic only stretches the cycle; the image follows cycle_start
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			image_r <= '0;
		else if (cycle_start)
			image_r <= filt_r;
	end

	// Previous synchronised levels, reset to the idle low level of the pins
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			prev_r <= '0;
		else
			prev_r <= sync2_r;
	end

	// Fast counter on terminal 1: raw rising edges, no debounce, no cycle tie
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			fast_counter_a <= '0;
		else if (sync2_r[0] && !prev_r[0])
			fast_counter_a <= fast_counter_a + FC_W'(1);
	end

	// Fast counter on terminal 2
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			fast_counter_b <= '0;
		else if (sync2_r[1] && !prev_r[1])
			fast_counter_b <= fast_counter_b + FC_W'(1);
	end

	// Fast counter on terminal 3
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			fast_counter_c <= '0;
		else if (sync2_r[2] && !prev_r[2])
			fast_counter_c <= fast_counter_c + FC_W'(1);
	end

	// Screen load timer: bytes times 80 us, independent of cycle
	// Screen size also sets the program memory share; budgeting is the caller's
	logic [31:0] scr_cnt_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scr_cnt_r     <= '0;
			screen_busy_r <= 1'b0;
		end else if (screen_load && screen_bytes != 16'h0000) begin
			scr_cnt_r     <= 32'(screen_bytes) * 32'(SCREEN_B_CYC);
			screen_busy_r <= 1'b1;
		end else if (scr_cnt_r > 32'h1) begin
			scr_cnt_r <= scr_cnt_r - 32'h1;
		end else begin
			scr_cnt_r     <= '0;
			screen_busy_r <= 1'b0;
		end
	end
endmodule

// ===== testbench/ids_scanner_asserts.sv
// Port checker of the input debounce scanner
module ids_scanner_asserts import ids_pkg::*; #(
	parameter int unsigned DEB_CYC = DEB_DC_CYC
) (
	input wire logic              clk_sys,         // Clock
	input wire logic              rst,             // Reset
	input wire logic [NUM_IN-1:0] input_terminals, // Terminals
	input wire ids_cfg_t          cfg,             // Setting
	input wire logic              cycle_start,     // Cycle start
	input wire logic [15:0]       screen_bytes,    // Screen size
	input wire logic              screen_load,     // Load pulse
	input wire logic [NUM_IN-1:0] image_r,         // Image
	input wire logic [FC_W-1:0]   fast_counter_a,  // Counter 1
	input wire logic              screen_busy_r    // Busy
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [15:0] hi_r, lo_r; // Run lengths of terminal 1
	// Saturating high and low run lengths
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hi_r <= 16'h0000;
			lo_r <= 16'h0000;
		end else begin
			hi_r <= input_terminals[0] ? hi_r + {15'h0000, ~&hi_r} : 16'h0000;
			lo_r <= !input_terminals[0] ? lo_r + {15'h0000, ~&lo_r} : 16'h0000;
		end
	end
	sequence s_load; screen_load && screen_bytes != 16'h0000; endsequence
	sequence s_held; screen_busy_r [*8]; endsequence
	property p_frozen; !$past(cycle_start) |-> $stable(image_r); endproperty
	a_frozen: assert property (p_frozen) else $error("image moved");
	property p_on; $rose(image_r[0]) && cfg == 3'h4 |-> hi_r >= DEB_CYC; endproperty
	a_on: assert property (p_on) else $error("early set");
	property p_off; $fell(image_r[0]) && cfg == 3'h4 |-> lo_r >= DEB_CYC; endproperty
	a_off: assert property (p_off) else $error("early clear");
	property p_raw; $rose(image_r[0]) && cfg == 3'h0 |-> hi_r >= 16'h04E2; endproperty
	a_raw: assert property (p_raw) else $error("early raw set");
	property p_busy; s_load |=> s_held; endproperty
	a_busy: assert property (p_busy) else $error("busy short");
	property p_idle; !screen_busy_r && !screen_load |=> !screen_busy_r; endproperty
	a_idle: assert property (p_idle) else $error("busy unasked");
	property p_cnt; $changed(fast_counter_a) |-> fast_counter_a == $past(fast_counter_a) + 16'h0001;
	endproperty
	a_cnt: assert property (p_cnt) else $error("count step");
	property p_quiet; (!input_terminals[0]) [*5] |=> $stable(fast_counter_a); endproperty
	a_quiet: assert property (p_quiet) else $error("count no edge");
endmodule
bind ids_scanner ids_scanner_asserts #(.DEB_CYC(DEB_CYC)) ids_scanner_asserts_inst (.*);

// ===== testbench/ids_field_model.sv
// Field switches: DC level, mains half-waves, contact chatter
module ids_field_model import ids_pkg::*; (
	input  wire logic              clk_sys,         // Clock
	input  wire logic [NUM_IN-1:0] want,            // Contacts closed
	input  wire logic              ac,              // Half-wave supply
	input  wire logic              bounce,          // Chatter
	output logic      [NUM_IN-1:0] input_terminals  // Terminal levels
);
	logic [2:0] ph_r = 3'h0; // Mains and chatter phase
	always @(posedge clk_sys) ph_r <= ph_r + 3'h1;
	// Half-wave on half the phase, chatter toggles each cycle
	assign input_terminals = want & (ac ? {NUM_IN{ph_r[2]}} : '1)
		^ (bounce ? want & {NUM_IN{ph_r[0]}} : '0);
endmodule

// ===== testbench/ids_scanner_tb.sv
// Self-checking bench of the input debounce scanner
module ids_scanner_tb import ids_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, rst = 1'b1, cycle_start = 1'b0, screen_load = 1'b0, ac = 1'b0;
	logic bounce = 1'b0, screen_busy_r;
	logic [NUM_IN-1:0] want = '0, input_terminals, image_r;
	logic [FC_W-1:0] fast_counter_a, fast_counter_b, fast_counter_c;
	logic [15:0] screen_bytes = 16'h0000;
	ids_cfg_t cfg = 3'h0;
	int err_count = 0, total_checks = 0;
	always #10 clk_sys = ~clk_sys;
	ids_field_model ids_field_model_inst (.*);
	ids_scanner #(.DEB_CYC(40), .L50_CYC(30), .L60_CYC(24), .S50_CYC(16), .S60_CYC(12))
		ids_scanner_inst (.*);
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic cmp(input string n, input logic [15:0] e, s);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// Cycle start pulse, then image compare
	task automatic img(input logic [NUM_IN-1:0] e);
		cycle_start = 1'b1;
		cyc(1);
		cycle_start = 1'b0;
		cyc(1);
		cmp("image", {4'h0, e}, {4'h0, image_r});
	endtask
	task automatic step(input logic [NUM_IN-1:0] w, input int n, input logic [NUM_IN-1:0] e);
		want = w;
		cyc(n);
		img(e);
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Watchdog, about twice the planned run
	initial begin
		#1500000;
		err_count++;
		tally_and_finish;
	end
	initial begin
		cyc(10);
		rst = 1'b0;
		for (int i = 0; i < 5; i++) begin
			want[2:0] = i < 2 ? 3'h7 : i < 3 ? 3'h3 : 3'h1;
			cyc(4);
			want = '0;
			cyc(4);
		end
		cmp("count a", 16'h0005, fast_counter_a);
		cmp("count b", 16'h0003, fast_counter_b);
		cmp("count c", 16'h0002, fast_counter_c);
		step(12'h051, 1260, 12'h001);
		step(12'h051, 11250, 12'h051);
		step(12'h001, 10010, 12'h011);
		step(12'h001, 10000, 12'h001);
		cfg = 3'h4;
		step(12'h000, 20, 12'h001);
		step(12'h000, 40, 12'h000);
		step(12'h001, 30, 12'h000);
		step(12'h001, 20, 12'h001);
		want = '0;
		cyc(60);
		cmp("frozen", 16'h0001, {4'h0, image_r});
		img(12'h000);
		ac = 1'b1;
		for (int m = 0; m < 2; m++) begin
			cfg = ids_cfg_t'({2'h3, m[0]});
			step(12'h001, 10, 12'h000);
			step(12'h001, m ? 72 : 90, 12'h001);
			step(12'h000, 10, 12'h001);
			step(12'h000, m ? 72 : 90, 12'h000);
		end
		cfg = 3'h2;
		bounce = 1'b1;
		step(12'h001, 48, 12'h001);
		bounce = 1'b0;
		step(12'h000, 40, 12'h000);
		screen_bytes = 16'h0001;
		screen_load = 1'b1;
		cyc(1);
		screen_load = 1'b0;
		cyc(3990);
		cmp("busy", 16'h0001, {15'h0000, screen_busy_r});
		cyc(20);
		cmp("busy", 16'h0000, {15'h0000, screen_busy_r});
		tally_and_finish;
	end
endmodule
